// file: vbuf_consts.vh
// Purpose: Constants for the display buffer DRAM pin controller
// Assumes: 100 MHz system clock, fast-page-mode DRAM
// Notes: Definitions only
`ifndef VBUF_CONSTS_VH
`define VBUF_CONSTS_VH

// Bank fitting configurations
`define CFG_TWO_X4 2'h0
`define CFG_THREE_X4 2'h1
`define CFG_FOUR_X4 2'h2
`define CFG_ONE_X16 2'h3

// Host address layout
`define HOST_ADDR_W 24
`define HOST_HIGH_LSB 17
`define HOST_LOW_W 17
`define HOST_HIGH_W 7
`define BELOW_MEG_LIMIT 24'h0fffff

// DRAM geometry
`define DRAM_ADDR_W 9
`define DRAM_DATA_W 8

// Timing in ns and derived cycle counts at 10 ns
`define CLK_PERIOD_NS 10
`define T_RAS_PRE_NS 60
`define T_RCD_NS 30
`define T_CAS_NS 20
`define T_RP_NS 50
`define RAS_PRE_CYC ((`T_RAS_PRE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RCD_CYC ((`T_RCD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CAS_CYC ((`T_CAS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RP_CYC ((`T_RP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// file: vbuf_sync2.v
// Purpose: Two-flop synchroniser for a bus of pin inputs
// Assumes: Single clock clk_sys_i
// Notes: First stage read only by second stage
`timescale 1ns/1ps
module vbuf_sync2 #(
  parameter W = 1
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] meta_r;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      meta_r <= {W{1'b0}};
      q_o <= {W{1'b0}};
    end else begin
      meta_r <= d_i;
      q_o <= meta_r;
    end
  end
endmodule // vbuf_sync2

// file: video_buffer_dram_pins.v
// What this block does
// - Drives two to four 256K x4 DRAMs in two banks, or one 256K x16.
// - Each bank has its own 9-bit row/column address bus, bit 8 the MSB.
// - Each bank has its own two-way 8-bit data bus, bits 7 to 0.
// - With x4 parts, bank A strobes serve parts 1 and 2 together.
// - Bank B strobes serve part 3 alone, or parts 3 and 4.
// - With a x16 part, bank A CAS is the lower byte, bank B CAS upper.
// - With a x16 part, only the bank A RAS goes to the DRAM.
// - With a x16 part, bank A write and output enables drive it.
// - Bank B has write and output enables independent of bank A.
// - 12-bit strap set: top pin is an active-low below-1MB decode input.
// - Otherwise the top address pin is bit 23 of a 24-bit address.
//
// Purpose: Display buffer DRAM pin controller, one access per request
// Assumes: Requests come from logic on clk_sys_i; straps and host
//          address pins are asynchronous and are synchronised here
// Notes: Accesses are 16-bit words, bank A low byte, bank B high byte
`timescale 1ns/1ps
`include "vbuf_consts.vh"
module video_buffer_dram_pins #(
  parameter ROW_W = 9,
  parameter COL_W = 9
) (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [1:0] mem_config_i,
  input wire panel_width_strap_i,
  input wire host_addr_top_bit_i,
  input wire [6:0] host_latched_high_addr_i,
  input wire [16:0] host_low_addr_i,
  input wire req_i,
  input wire req_wr_i,
  input wire [1:0] req_byte_en_i,
  input wire [ROW_W-1:0] req_row_i,
  input wire [COL_W-1:0] req_col_i,
  input wire [15:0] req_wdata_i,
  output reg req_ready_o,
  output reg rd_valid_o,
  output reg [15:0] rd_data_o,
  output reg host_hit_o,
  output reg [23:0] host_addr_o,
  output reg [8:0] bank0_mem_addr_o,
  output reg [8:0] bank1_mem_addr_o,
  input wire [7:0] bank0_mem_data_i,
  output reg [7:0] bank0_mem_data_o,
  output reg bank0_mem_data_oe_o,
  input wire [7:0] bank1_mem_data_i,
  output reg [7:0] bank1_mem_data_o,
  output reg bank1_mem_data_oe_o,
  output reg bank0_row_strobe_n_o,
  output reg bank1_row_strobe_n_o,
  output reg bank0_col_strobe_n_o,
  output reg bank1_col_strobe_n_o,
  output reg bank0_out_en_n_o,
  output reg bank1_out_en_n_o,
  output reg bank0_wr_en_n_o,
  output reg bank1_wr_en_n_o
);

  // ***************************************************
  // Constants and helpers
  // ***************************************************
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ROW = 3'h1;
  localparam [2:0] ST_COL = 3'h2;
  localparam [2:0] ST_DONE = 3'h3;
  localparam [2:0] ST_PRE = 3'h4;
  localparam integer RCD_I = `RCD_CYC;
  localparam integer CAS_I = `CAS_CYC;
  localparam integer RP_I = `RP_CYC;
  localparam integer RAS_I = `RAS_PRE_CYC;
  localparam [3:0] RCD_N = RCD_I[3:0];
  localparam [3:0] CAS_N = CAS_I[3:0];
  localparam [3:0] RP_N = RP_I[3:0];
  localparam [3:0] RAS_N = RAS_I[3:0];

  // Bank B fitted in this configuration
  function bank1_fitted;
    input [1:0] cfg;
    begin
      bank1_fitted = (cfg == `CFG_THREE_X4) || (cfg == `CFG_FOUR_X4);
    end
  endfunction

  // Single x16 part fitted
  function is_x16;
    input [1:0] cfg;
    begin
      is_x16 = (cfg == `CFG_ONE_X16);
    end
  endfunction

  // ***************************************************
  // Pin synchronisers
  // ***************************************************
  wire [27:0] pins_sync;
  wire [1:0] cfg;
  wire strap_s;
  wire top_s;
  wire [6:0] high_s;
  wire [16:0] low_s;

  vbuf_sync2 #(
    .W(28)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .d_i({mem_config_i, panel_width_strap_i, host_addr_top_bit_i,
          host_latched_high_addr_i, host_low_addr_i}),
    .q_o(pins_sync)
  );

  assign cfg = pins_sync[27:26];
  assign strap_s = pins_sync[25];
  assign top_s = pins_sync[24];
  assign high_s = pins_sync[23:17];
  assign low_s = pins_sync[16:0];

  // ***************************************************
  // Host address formation
  // ***************************************************
  reg [23:0] addr_nxt;
  reg hit_nxt;

  always @* begin
    if (strap_s) begin
      // Top pin is a below-1MB decode, upper bits forced to zero
      addr_nxt = {4'h0, high_s[2:0], low_s};
      hit_nxt = ~top_s;
    end else begin
      addr_nxt = {top_s, high_s[5:0], low_s};
      hit_nxt = ({top_s, high_s[5:0], low_s} <= `BELOW_MEG_LIMIT);
    end
  end

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      host_addr_o <= 24'h000000;
      host_hit_o <= 1'b0;
    end else begin
      host_addr_o <= addr_nxt;
      host_hit_o <= hit_nxt;
    end
  end

  // ***************************************************
  // Access sequencer
  // ***************************************************
  reg [2:0] state_r;
  reg [3:0] cnt_r;
  reg wr_r;
  reg [1:0] be_r;
  reg [COL_W-1:0] col_r;
  reg [15:0] wdata_r;
  reg b1_fit_r;
  reg x16_r;

  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      wr_r <= 1'b0;
      be_r <= 2'h0;
      col_r <= {COL_W{1'b0}};
      wdata_r <= 16'h0000;
      b1_fit_r <= 1'b0;
      x16_r <= 1'b0;
      req_ready_o <= 1'b0;
      rd_valid_o <= 1'b0;
      rd_data_o <= 16'h0000;
      bank0_mem_addr_o <= 9'h000;
      bank1_mem_addr_o <= 9'h000;
      bank0_mem_data_o <= 8'h00;
      bank1_mem_data_o <= 8'h00;
      bank0_mem_data_oe_o <= 1'b0;
      bank1_mem_data_oe_o <= 1'b0;
      bank0_row_strobe_n_o <= 1'b1;
      bank1_row_strobe_n_o <= 1'b1;
      bank0_col_strobe_n_o <= 1'b1;
      bank1_col_strobe_n_o <= 1'b1;
      bank0_out_en_n_o <= 1'b1;
      bank1_out_en_n_o <= 1'b1;
      bank0_wr_en_n_o <= 1'b1;
      bank1_wr_en_n_o <= 1'b1;
    end else begin
      rd_valid_o <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          req_ready_o <= 1'b1;
          if (req_i && req_ready_o) begin
            req_ready_o <= 1'b0;
            wr_r <= req_wr_i;
            be_r <= req_byte_en_i;
            col_r <= req_col_i;
            wdata_r <= req_wdata_i;
            b1_fit_r <= bank1_fitted(cfg);
            x16_r <= is_x16(cfg);
            // Both banks get the same multiplexed row
            bank0_mem_addr_o <= req_row_i[8:0];
            bank1_mem_addr_o <= req_row_i[8:0];
            state_r <= ST_ROW;
          end
        end
        ST_ROW: begin
          // Bank A RAS covers parts 1 and 2, or the x16 part
          bank0_row_strobe_n_o <= 1'b0;
          // Bank B RAS only with parts 3 (and 4) fitted
          bank1_row_strobe_n_o <= ~b1_fit_r;
          cnt_r <= RCD_N;
          state_r <= ST_COL;
        end
        ST_COL: begin
          if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            bank0_mem_addr_o <= col_r[8:0];
            bank1_mem_addr_o <= col_r[8:0];
            bank0_mem_data_o <= wdata_r[7:0];
            bank1_mem_data_o <= wdata_r[15:8];
            bank0_mem_data_oe_o <= wr_r;
            bank1_mem_data_oe_o <= wr_r & (b1_fit_r | x16_r);
            bank0_wr_en_n_o <= ~wr_r;
            bank0_out_en_n_o <= wr_r;
            // Bank B enables are its own, idle in x16 use
            bank1_wr_en_n_o <= ~(wr_r & b1_fit_r);
            bank1_out_en_n_o <= ~(~wr_r & b1_fit_r);
            // Lower byte CAS on A, upper byte CAS on B
            bank0_col_strobe_n_o <= ~be_r[0];
            bank1_col_strobe_n_o <=
              ~(be_r[1] & (b1_fit_r | x16_r));
            cnt_r <= CAS_N + 4'h1;
            state_r <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            if (!wr_r) begin
              // x16 upper byte shares the bank B data pins
              rd_data_o <= {bank1_mem_data_i, bank0_mem_data_i};
              rd_valid_o <= 1'b1;
            end
            bank0_row_strobe_n_o <= 1'b1;
            bank1_row_strobe_n_o <= 1'b1;
            bank0_col_strobe_n_o <= 1'b1;
            bank1_col_strobe_n_o <= 1'b1;
            bank0_out_en_n_o <= 1'b1;
            bank1_out_en_n_o <= 1'b1;
            bank0_wr_en_n_o <= 1'b1;
            bank1_wr_en_n_o <= 1'b1;
            bank0_mem_data_oe_o <= 1'b0;
            bank1_mem_data_oe_o <= 1'b0;
            cnt_r <= (RP_N > RAS_N) ? RP_N : RAS_N;
            state_r <= ST_PRE;
          end
        end
        ST_PRE: begin
          if (cnt_r > 4'h1) begin
            cnt_r <= cnt_r - 4'h1;
          end else begin
            state_r <= ST_IDLE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // video_buffer_dram_pins

// file: vbuf_props.sv
// Purpose: Assertions on the DRAM pin controller ports
// Assumes: Straps steady while an access runs
// Notes: Bound to the top module
`timescale 1ns/1ps
module vbuf_props (
  input wire clk_sys_i,
  input wire rst_i,
  input wire [1:0] mem_config_i,
  input wire req_ready_o,
  input wire rd_valid_o,
  input wire bank0_mem_data_oe_o,
  input wire bank0_row_strobe_n_o,
  input wire bank1_row_strobe_n_o,
  input wire bank0_col_strobe_n_o,
  input wire bank1_col_strobe_n_o,
  input wire bank0_out_en_n_o,
  input wire bank1_out_en_n_o,
  input wire bank0_wr_en_n_o,
  input wire bank1_wr_en_n_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  a_idle_strobes_off: assert property (
    req_ready_o |-> bank0_row_strobe_n_o && bank0_col_strobe_n_o)
    else $error("strobe active while idle");
  a_cas_in_row: assert property (
    $fell(bank0_col_strobe_n_o) |-> !bank0_row_strobe_n_o)
    else $error("column strobe without row strobe");
  a_two_part_idle: assert property (
    mem_config_i == 2'h0 |-> bank1_row_strobe_n_o && bank1_col_strobe_n_o)
    else $error("bank B strobe in two-part use");
  a_wide_bank1_idle: assert property (
    mem_config_i == 2'h3 |-> bank1_row_strobe_n_o && bank1_wr_en_n_o
      && bank1_out_en_n_o)
    else $error("bank B control in wide use");
  a_upper_cas_row: assert property (
    mem_config_i == 2'h3 && !bank1_col_strobe_n_o |-> !bank0_row_strobe_n_o)
    else $error("upper strobe outside row cycle");
  a_bank1_ras_track: assert property (
    mem_config_i inside {2'h1, 2'h2} |->
      bank1_row_strobe_n_o == bank0_row_strobe_n_o)
    else $error("bank B row strobe out of step");
  a_read_one_pulse: assert property (
    rd_valid_o |=> !rd_valid_o)
    else $error("read valid too long");
  a_no_bus_clash: assert property (
    bank0_mem_data_oe_o |-> bank0_out_en_n_o)
    else $error("data driven with DRAM output on");
  c_read: cover property (rd_valid_o);
  c_upper: cover property (mem_config_i == 2'h3 && !bank1_col_strobe_n_o);
  c_write: cover property (!bank0_wr_en_n_o && !bank0_col_strobe_n_o);
endmodule // vbuf_props
bind video_buffer_dram_pins vbuf_props vbuf_props_inst (.*);

// file: vbuf_dram_model.sv
// Purpose: Behavioural fast-page DRAM byte lane
// Assumes: Early write, data valid at column strobe
// Notes: Released bus shows the inverse of the last byte
`timescale 1ns/1ps
module vbuf_dram_model (
  input wire [8:0] addr_i,
  input wire ras_n_i,
  input wire cas_n_i,
  input wire oe_n_i,
  input wire we_n_i,
  input wire [7:0] dq_i,
  output logic [7:0] dq_o
);
  logic [8:0] row_r;
  logic [7:0] last_r = 8'h00;
  logic [7:0] mem_r [bit [17:0]];
  initial dq_o = 8'h00;
  always @(negedge ras_n_i) row_r = addr_i;
  always @(negedge cas_n_i) begin
    #1;
    if (!we_n_i) mem_r[{row_r, addr_i}] = dq_i;
  end
  always @(negedge cas_n_i or negedge oe_n_i) begin
    #2;
    if (!cas_n_i && !oe_n_i) begin
      last_r = mem_r[{row_r, addr_i}];
      dq_o = last_r;
    end
  end
  always @(posedge cas_n_i or posedge oe_n_i) dq_o = ~last_r;
endmodule // vbuf_dram_model

// file: video_buffer_dram_pins_test.sv
// Purpose: Self-checking bench for the DRAM pin controller
// Assumes: Inputs driven at the falling clock edge
// Notes: Two DRAM lane models stand behind the banks
`timescale 1ns/1ps
module video_buffer_dram_pins_test;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [1:0] cfg = 2'h2;
  logic strap = 1'b0;
  logic top = 1'b0;
  logic [6:0] hi = 7'h00;
  logic [16:0] lo = 17'h00000;
  logic req = 1'b0;
  logic wr = 1'b0;
  logic [1:0] be = 2'h3;
  logic [8:0] row = 9'h000;
  logic [8:0] col = 9'h000;
  logic [15:0] wd = 16'h0000;
  wire rdy, rv, hit, oe0, oe1, r0, r1, c0, c1, o0, o1, w0, w1;
  wire [15:0] rdat;
  wire [23:0] haddr;
  wire [8:0] a0, a1;
  wire [7:0] d0, d1, m0, m1;
  wire x16 = cfg == 2'h3;
  wire [7:0] bus0 = oe0 ? d0 : m0;
  wire [7:0] bus1 = oe1 ? d1 : m1;
  int err_total = 0;
  int num_checks = 0;
  video_buffer_dram_pins video_buffer_dram_pins_inst (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .mem_config_i(cfg),
    .panel_width_strap_i(strap), .host_addr_top_bit_i(top),
    .host_latched_high_addr_i(hi), .host_low_addr_i(lo), .req_i(req),
    .req_wr_i(wr), .req_byte_en_i(be), .req_row_i(row), .req_col_i(col),
    .req_wdata_i(wd), .req_ready_o(rdy), .rd_valid_o(rv),
    .rd_data_o(rdat), .host_hit_o(hit), .host_addr_o(haddr),
    .bank0_mem_addr_o(a0), .bank1_mem_addr_o(a1),
    .bank0_mem_data_i(bus0), .bank0_mem_data_o(d0),
    .bank0_mem_data_oe_o(oe0), .bank1_mem_data_i(bus1),
    .bank1_mem_data_o(d1), .bank1_mem_data_oe_o(oe1),
    .bank0_row_strobe_n_o(r0), .bank1_row_strobe_n_o(r1),
    .bank0_col_strobe_n_o(c0), .bank1_col_strobe_n_o(c1),
    .bank0_out_en_n_o(o0), .bank1_out_en_n_o(o1),
    .bank0_wr_en_n_o(w0), .bank1_wr_en_n_o(w1));
  vbuf_dram_model vbuf_dram_model_inst (.addr_i(a0), .ras_n_i(r0),
    .cas_n_i(c0), .oe_n_i(o0), .we_n_i(w0), .dq_i(bus0), .dq_o(m0));
  vbuf_dram_model vbuf_dram_model_hi_inst (.addr_i(x16 ? a0 : a1),
    .ras_n_i(x16 ? r0 : r1), .cas_n_i(c1), .oe_n_i(x16 ? o0 : o1),
    .we_n_i(x16 ? w0 : w1), .dq_i(bus1), .dq_o(m1));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  task close_out;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input logic [24:0] g, input logic [24:0] e);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task acc(input logic w, input logic [1:0] b, input logic [8:0] r,
    input logic [8:0] c, input logic [15:0] d);
    int n;
    for (n = 0; !rdy && n < 40; n++) @(negedge clk_sys_i);
    chk(rdy, 1'b1);
    wr = w; be = b; row = r; col = c; wd = d; req = 1'b1;
    @(negedge clk_sys_i);
    req = 1'b0;
    for (n = 0; !w && !rv && n < 30; n++) @(negedge clk_sys_i);
    if (!w) chk(rv, 1'b1);
    @(negedge clk_sys_i);
  endtask
  task t_host;
    top = 1'b1; hi = 7'h15; lo = 17'h1abcd;
    repeat (5) @(negedge clk_sys_i);
    chk({hit, haddr}, {1'b0, 1'b1, 6'h15, 17'h1abcd});
    top = 1'b0; hi = 7'h07;
    repeat (5) @(negedge clk_sys_i);
    chk({hit, haddr}, {1'b1, 1'b0, 6'h07, 17'h1abcd});
    strap = 1'b1;
    hi = 7'h7f;
    repeat (5) @(negedge clk_sys_i);
    chk({hit, haddr}, {1'b1, 4'h0, 3'h7, 17'h1abcd});
    top = 1'b1;
    repeat (5) @(negedge clk_sys_i);
    chk({hit, haddr}, {1'b0, 4'h0, 3'h7, 17'h1abcd});
    strap = 1'b0;
  endtask
  task t_rw(input logic [1:0] c, input logic [15:0] m);
    cfg = c;
    repeat (5) @(negedge clk_sys_i);
    acc(1'b1, 2'h3, 9'h1a5, 9'h05a, 16'h3c5a + c);
    acc(1'b1, 2'h3, 9'h05a, 9'h1a5, 16'hc3a5 - c);
    acc(1'b0, 2'h3, 9'h1a5, 9'h05a, 16'h0000);
    chk(rdat & m, (16'h3c5a + c) & m);
    acc(1'b0, 2'h3, 9'h05a, 9'h1a5, 16'h0000);
    chk(rdat & m, (16'hc3a5 - c) & m);
  endtask
  task t_bytes(input logic [1:0] c, input logic [1:0] b);
    cfg = c;
    repeat (5) @(negedge clk_sys_i);
    acc(1'b1, 2'h3, 9'h011, 9'h022, 16'h5678);
    acc(1'b1, b, 9'h011, 9'h022, 16'habcd);
    acc(1'b0, 2'h3, 9'h011, 9'h022, 16'h0000);
    chk(rdat, b[1] ? 16'hab78 : 16'h56cd);
  endtask
  initial begin
    #100000;
    err_total++;
    close_out;
  end
  initial begin
    repeat (4) @(negedge clk_sys_i);
    rst_i = 1'b0;
    repeat (3) @(negedge clk_sys_i);
    t_host;
    t_rw(2'h0, 16'h00ff);
    t_rw(2'h1, 16'hffff);
    t_rw(2'h2, 16'hffff);
    t_rw(2'h3, 16'hffff);
    t_bytes(2'h3, 2'h2);
    t_bytes(2'h2, 2'h1);
    close_out;
  end
endmodule // video_buffer_dram_pins_test
